// file: core/fac_host.sv
// Host controller issuing command sequences to a bottom-boot parallel flash
// Behaviour
// - Byte mode drives A17..A-1, word mode drives A17..A0.
// - Program is two unlock writes, setup code, then address and data write.
// - Address latched on strobe fall, data on strobe rise.
// - Elevated select voltage on A9 is for programmers; host uses commands.
// - Protect check uses sector address with A1 high, A0 low; 01h protected.
// - Unlock addresses 555h/2AAh word, AAAh/555h byte.
module fac_host
  import fac_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // User request
  input wire logic i_req,
  input wire fac_op_t i_op,
  input wire logic i_byte_mode,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_addr_lsb,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_sector,
  input wire logic [1:0] i_id_sel,
  output logic o_busy,
  output logic o_done,
  output logic o_erase_active,
  output logic [DATA_W-1:0] o_rdata,
  // Flash pins
  output logic o_fl_ce_n,
  output logic o_fl_oe_n,
  output logic o_fl_we_n,
  output logic o_fl_byte_n,
  output logic [ADDR_W-1:0] o_fl_addr,
  output logic o_fl_alsb,
  output logic o_fl_alsb_oe,
  output logic [DATA_W-2:0] o_fl_dq,
  output logic o_fl_dq_oe,
  input wire logic [DATA_W-1:0] i_fl_dq,
  input wire logic i_fl_ready_busy_n
);
  fac_state_t state_q;
  fac_op_t op_q;
  logic [2:0] step_q;
  logic [2:0] nsteps_q;
  logic [CNT_W-1:0] cnt_q;
  logic [ADDR_W-1:0] tgt_addr_q;
  logic tgt_lsb_q;
  logic [DATA_W-1:0] tgt_data_q;
  logic byte_q;
  logic last_tog_q;
  logic poll_first_q;
  logic [ADDR_W-1:0] cyc_addr;
  logic cyc_lsb;
  logic [DATA_W-1:0] cyc_data;
  logic need_poll;
  logic final_read;

  // Unlock address at A10..A0 in word mode, A10..A-1 in byte mode
  function automatic logic [11:0] unl_addr(input logic bm, input logic second);
    logic [11:0] a;
    a = 12'h000;
    if (bm) begin
      a = second ? UNL2_BYTE : UNL1_BYTE;
    end else begin
      a = {second ? UNL2_WORD : UNL1_WORD, 1'b0};
    end
    return a;
  endfunction

  // Command cycle address/data for the current step
  always_comb begin
    logic [11:0] ua;
    logic [7:0] cd;
    ua = 12'h000;
    cd = 8'h00;
    cyc_addr = tgt_addr_q;
    cyc_lsb = tgt_lsb_q;
    cyc_data = tgt_data_q;
    if (op_q == FAC_OP_SUSP || op_q == FAC_OP_RESUME || op_q == FAC_OP_RESET) begin
      // Single-cycle commands; suspend/resume sent on any request, o_erase_active not checked
      cd = (op_q == FAC_OP_SUSP) ? CMD_SUSP : ((op_q == FAC_OP_RESUME) ? CMD_RESUME
        : CMD_RESET);
      cyc_data = {8'h00, cd};
    end else if (step_q == nsteps_q - 3'h1 && op_q != FAC_OP_CHIP && op_q != FAC_OP_ID) begin
      // Final cycle carries target address: program data or sector select
      if (op_q == FAC_OP_SECT) begin
        cyc_data = {8'h00, CMD_SECT};
      end else begin
        cyc_data = tgt_data_q;
      end
    end else begin
      case (step_q)
        3'h0, 3'h3: begin
          ua = unl_addr(byte_q, 1'b0);
          cd = CMD_UNL1;
        end
        3'h1, 3'h4: begin
          ua = unl_addr(byte_q, 1'b1);
          cd = CMD_UNL2;
        end
        3'h2: begin
          ua = unl_addr(byte_q, 1'b0);
          cd = (op_q == FAC_OP_PROG) ? CMD_PROG : ((op_q == FAC_OP_ID) ? CMD_IDSEL
            : CMD_ERASE);
        end
        default: begin
          ua = unl_addr(byte_q, 1'b0);
          cd = CMD_CHIP;
        end
      endcase
      cyc_addr = {7'h00, ua[11:1]};
      cyc_lsb = ua[0];
      cyc_data = {8'h00, cd};
    end
  end

  // Sector erase is left running so a suspend can follow; resume waits for its end
  assign need_poll = (op_q == FAC_OP_PROG) || (op_q == FAC_OP_CHIP) || (op_q == FAC_OP_RESUME);
  assign final_read = (op_q == FAC_OP_READ) || (op_q == FAC_OP_ID);

  // Sequencer
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= FAC_IDLE;
      op_q <= FAC_OP_READ;
      step_q <= 3'h0;
      nsteps_q <= 3'h0;
      cnt_q <= CNT_ZERO;
      tgt_addr_q <= '0;
      tgt_lsb_q <= 1'b0;
      tgt_data_q <= '0;
      byte_q <= 1'b0;
      last_tog_q <= 1'b0;
      poll_first_q <= 1'b0;
      o_rdata <= '0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      unique case (state_q)
        FAC_IDLE: begin
          if (i_req) begin
            op_q <= i_op;
            byte_q <= i_byte_mode;
            tgt_lsb_q <= i_byte_mode ? i_addr_lsb : 1'b0;
            tgt_data_q <= i_wdata;
            step_q <= 3'h0;
            cnt_q <= WE_LOW_CNT;
            state_q <= FAC_WLOW;
            tgt_addr_q <= i_addr;
            case (i_op)
              FAC_OP_READ: begin
                nsteps_q <= 3'h0;
                cnt_q <= RD_ACC_CNT;
                state_q <= FAC_RACC;
              end
              FAC_OP_PROG: nsteps_q <= 3'h4;
              FAC_OP_CHIP: nsteps_q <= 3'h6;
              FAC_OP_SECT: begin
                nsteps_q <= 3'h6;
                tgt_addr_q <= {fac_sector_base(i_sector), 12'h000};
              end
              FAC_OP_ID: begin
                nsteps_q <= 3'h3;
                // A6=0, A1/A0 pick code; sector address is added for every code, used by protect check
                tgt_addr_q <= {fac_sector_base(i_sector), 10'h000, i_id_sel};
              end
              default: nsteps_q <= 3'h1;
            endcase
          end
        end
        FAC_WLOW: begin
          if (cnt_q == CNT_ONE) begin
            cnt_q <= WE_HIGH_CNT;
            state_q <= FAC_WHIGH;
          end else begin
            cnt_q <= cnt_q - CNT_ONE;
          end
        end
        FAC_WHIGH: begin
          if (cnt_q != CNT_ONE) begin
            cnt_q <= cnt_q - CNT_ONE;
          end else if (step_q != nsteps_q - 3'h1) begin
            step_q <= step_q + 3'h1;
            cnt_q <= WE_LOW_CNT;
            state_q <= FAC_WLOW;
          end else if (final_read) begin
            cnt_q <= RD_ACC_CNT;
            state_q <= FAC_RACC;
          end else if (need_poll) begin
            poll_first_q <= 1'b1;
            cnt_q <= RD_ACC_CNT;
            state_q <= FAC_POLL;
          end else begin
            state_q <= FAC_DONE;
          end
        end
        FAC_RACC: begin
          if (cnt_q == CNT_ONE) begin
            // Upper byte is don't-care in byte mode
            o_rdata <= byte_q ? {8'h00, i_fl_dq[7:0]} : i_fl_dq;
            state_q <= FAC_DONE;
          end else begin
            cnt_q <= cnt_q - CNT_ONE;
          end
        end
        FAC_POLL: begin
          if (cnt_q == CNT_ONE) begin
            last_tog_q <= i_fl_dq[TOGGLE_BIT];
            poll_first_q <= 1'b0;
            cnt_q <= RD_ACC_CNT;
            // Two reads with equal toggle bit and ready line mean done
            if (!poll_first_q && i_fl_dq[TOGGLE_BIT] == last_tog_q &&
                i_fl_ready_busy_n) begin
              o_rdata <= i_fl_dq;
              state_q <= FAC_DONE;
            end
          end else begin
            cnt_q <= cnt_q - CNT_ONE;
          end
        end
        FAC_DONE: begin
          o_done <= 1'b1;
          state_q <= FAC_IDLE;
        end
        default: state_q <= FAC_IDLE;
      endcase
    end
  end

  // Erase-in-progress tracker; the sequencer sends suspend/resume without checking it
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_erase_active <= 1'b0;
    end else if (i_ce && state_q == FAC_IDLE && i_req) begin
      if (i_op == FAC_OP_SECT) begin
        o_erase_active <= 1'b1;
      end else if (i_op == FAC_OP_RESET) begin
        o_erase_active <= 1'b0;
      end
    end else if (i_ce && state_q == FAC_DONE && op_q == FAC_OP_RESUME) begin
      o_erase_active <= 1'b0;
    end
  end

  // Pin drive registers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fl_ce_n <= 1'b1;
      o_fl_oe_n <= 1'b1;
      o_fl_we_n <= 1'b1;
      o_fl_byte_n <= 1'b1;
      o_fl_addr <= '0;
      o_fl_alsb <= 1'b0;
      o_fl_alsb_oe <= 1'b0;
      o_fl_dq <= '0;
      o_fl_dq_oe <= 1'b0;
      o_busy <= 1'b0;
    end else if (i_ce) begin
      o_busy <= (state_q != FAC_IDLE) || i_req;
      o_fl_byte_n <= !byte_q;
      o_fl_alsb_oe <= byte_q || state_q == FAC_WLOW || state_q == FAC_WHIGH;
      o_fl_we_n <= (state_q != FAC_WLOW);
      // Output enable rises between poll reads so the toggle bit can move
      o_fl_oe_n <= !(state_q == FAC_RACC || (state_q == FAC_POLL && cnt_q != CNT_ONE));
      o_fl_ce_n <= (state_q == FAC_IDLE || state_q == FAC_DONE);
      o_fl_dq_oe <= (state_q == FAC_WLOW || state_q == FAC_WHIGH);
      if (state_q == FAC_WLOW || state_q == FAC_WHIGH) begin
        o_fl_addr <= cyc_addr;
        // Shared pin carries data bit 15 in word mode
        o_fl_alsb <= byte_q ? cyc_lsb : cyc_data[DATA_W-1];
        o_fl_dq <= cyc_data[DATA_W-2:0];
      end else begin
        o_fl_addr <= tgt_addr_q;
        o_fl_alsb <= tgt_lsb_q;
      end
    end
  end
endmodule

// file: core/fac_pkg.sv
// Package for the flash command host: command codes, pin timing and sector map
package fac_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // Strobe timing in ns, converted to cycles rounding up
  localparam int unsigned T_WE_LOW_NS = 40;
  localparam int unsigned T_WE_HIGH_NS = 40;
  localparam int unsigned T_RD_ACC_NS = 96;
  localparam int unsigned T_WE_LOW_CYC = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned T_WE_HIGH_CYC = (T_WE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned T_RD_ACC_CYC = (T_RD_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] WE_LOW_CNT = CNT_W'(T_WE_LOW_CYC);
  localparam logic [CNT_W-1:0] WE_HIGH_CNT = CNT_W'(T_WE_HIGH_CYC);
  localparam logic [CNT_W-1:0] RD_ACC_CNT = CNT_W'(T_RD_ACC_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  // Address and data widths: A17..A0 plus byte address bit A-1
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 16;
  // Unlock addresses on A10..A0 (word) or A10..A-1 (byte)
  localparam logic [10:0] UNL1_WORD = 11'h555;
  localparam logic [10:0] UNL2_WORD = 11'h2AA;
  localparam logic [11:0] UNL1_BYTE = 12'hAAA;
  localparam logic [11:0] UNL2_BYTE = 12'h555;
  // Command data codes
  localparam logic [7:0] CMD_UNL1 = 8'hAA;
  localparam logic [7:0] CMD_UNL2 = 8'h55;
  localparam logic [7:0] CMD_PROG = 8'hA0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECT = 8'h30;
  localparam logic [7:0] CMD_IDSEL = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_SUSP = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  // Identifier-select read addresses (A6=0, A1/A0)
  localparam logic [1:0] ID_MANUF = 2'h0;
  localparam logic [1:0] ID_DEVICE = 2'h1;
  localparam logic [1:0] ID_PROTECT = 2'h2;
  localparam logic [7:0] PROT_YES = 8'h01;
  // Status bits in read data
  localparam int unsigned POLL_BIT = 7;
  localparam int unsigned TOGGLE_BIT = 6;
  // Operations requested by the user side
  typedef enum logic [2:0] {
    FAC_OP_READ = 3'b000,
    FAC_OP_PROG = 3'b001,
    FAC_OP_CHIP = 3'b010,
    FAC_OP_SECT = 3'b011,
    FAC_OP_ID = 3'b100,
    FAC_OP_SUSP = 3'b101,
    FAC_OP_RESUME = 3'b110,
    FAC_OP_RESET = 3'b111
  } fac_op_t;
  typedef enum logic [2:0] {
    FAC_IDLE = 3'b000,
    FAC_WLOW = 3'b001,
    FAC_WHIGH = 3'b010,
    FAC_RACC = 3'b011,
    FAC_POLL = 3'b100,
    FAC_DONE = 3'b101
  } fac_state_t;
  // Sector-select base (bits 17..12) of a bottom-boot sector index 0..10
  function automatic logic [5:0] fac_sector_base(input logic [3:0] idx);
    logic [5:0] base;
    base = 6'h00;
    case (idx)
      4'h0: base = 6'h00;
      4'h1: base = 6'h02;
      4'h2: base = 6'h03;
      4'h3: base = 6'h04;
      default: base = {idx[2:0] - 3'h3, 3'h0};
    endcase
    return base;
  endfunction
endpackage

// file: verification/fac_flash_model.sv
// Behavioural bottom-boot flash device
module fac_flash_model #(
  parameter logic [15:0] MANUF_CODE = 16'h005A, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h1234 // Arbitrary value
) (
  // Timing base
  input wire logic i_clk,
  // Flash pins
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_byte_n,
  input wire logic [17:0] i_addr,
  input wire logic i_alsb,
  input wire logic [14:0] i_dq,
  output logic [15:0] o_dq,
  output logic o_ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] key;
  logic [19:0] al = '0, pa = '0, ea = '0;
  logic [15:0] pd = 16'hFFFF, last = '0;
  logic [7:0] d;
  logic [2:0] step = '0;
  logic idm = 0, sect = 0, susp = 0, tog = 0, prog = 0, u1, u2;
  int tmr = 0;
  wire busy = tmr != 0 && !susp;
  assign key = {i_byte_n, i_addr, i_byte_n ? 1'b0 : i_alsb};
  assign o_ready_busy_n = !busy;
  // Latch once select and address settle: they move on the strobe's own edge
  always @(negedge i_we_n) #1 if (!i_ce_n) al = key;
  always @(posedge i_we_n) if (!i_ce_n) begin
    u1 = al[19] ? al[11:1] == 11'h555 : al[11:0] == 12'hAAA;
    u2 = al[19] ? al[11:1] == 11'h2AA : al[11:0] == 12'h555;
    d = i_dq[7:0];
    if (tmr != 0) begin
      if (sect) susp = d == 8'hB0 ? 1'b1 : d == 8'h30 ? 1'b0 : susp;
    end else begin
      idm = 1'b0;
      case (step)
        3'h0: step = u1 && d == 8'hAA ? 3'h1 : 3'h0;
        3'h1: step = u2 && d == 8'h55 ? 3'h2 : 3'h0;
        3'h2: begin
          step = u1 && d == 8'hA0 ? 3'h3 : u1 && d == 8'h80 ? 3'h4 : 3'h0;
          idm = u1 && d == 8'h90;
        end
        3'h3: begin
          pa = al;
          pd = {al[19] ? i_alsb : 1'b0, i_dq};
          prog = 1'b1;
          tmr = 40;
          step = 3'h0;
        end
        3'h4: step = u1 && d == 8'hAA ? 3'h5 : 3'h0;
        3'h5: step = u2 && d == 8'h55 ? 3'h6 : 3'h0;
        default: begin
          prog = 1'b0;
          sect = d == 8'h30;
          ea = al;
          if (sect || u1 && d == 8'h10) tmr = 300;
          step = 3'h0;
        end
      endcase
    end
  end
  always @(posedge i_clk) if (busy) begin
    tmr = tmr - 1;
    if (tmr == 0 && !prog && (!sect || pa[18:13] == ea[18:13])) pd = 16'hFFFF;
  end
  always @(negedge i_oe_n) if (busy) tog = ~tog;
  always @(posedge i_oe_n) last = o_dq;
  always @* begin
    if (i_ce_n || i_oe_n) o_dq = ~last;
    else if (busy) o_dq = {8'h00, prog ? ~pd[7] : 1'b0, tog, 6'h00};
    else if (idm && i_addr[6]) o_dq = 16'h0000;
    else if (idm) o_dq = key[2:1] == 2'h0 ? MANUF_CODE : key[2:1] == 2'h1 ? DEVICE_CODE
        : {15'h0, i_addr[17:14] == 4'h1};
    else o_dq = key == pa ? pd : 16'hFFFF;
    if (!i_byte_n && !i_oe_n) o_dq[15:8] = 8'hA5;
  end
endmodule

// file: verification/fac_host_chk.sv
// Pin protocol checker for the flash host
module fac_host_chk
  import fac_pkg::*;
(
  // Watched ports
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_req,
  input wire logic i_fl_ready_busy_n,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_erase_active,
  input wire logic o_fl_ce_n,
  input wire logic o_fl_oe_n,
  input wire logic o_fl_we_n,
  input wire logic [ADDR_W-1:0] o_fl_addr,
  input wire logic [DATA_W-2:0] o_fl_dq,
  input wire logic o_fl_dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_take; i_ce && i_req && !o_busy; endsequence
  sequence s_we_low; (!o_fl_we_n) [*5] ##1 o_fl_we_n; endsequence
  property p_we_len; $fell(o_fl_we_n) |-> s_we_low; endproperty
  a_we_len: assert property (p_we_len) else $error("write strobe width");
  property p_wr_hold;
    !o_fl_we_n && !$fell(o_fl_we_n) |-> $stable(o_fl_addr) && $stable(o_fl_dq);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write bus moved");
  property p_no_fight; o_fl_dq_oe |-> o_fl_oe_n; endproperty
  a_no_fight: assert property (p_no_fight) else $error("drive during read");
  property p_we_sel; !o_fl_we_n |-> !o_fl_ce_n && o_fl_dq_oe; endproperty
  a_we_sel: assert property (p_we_sel) else $error("write without select");
  property p_quiet; !i_fl_ready_busy_n && !o_erase_active |-> o_fl_we_n; endproperty
  a_quiet: assert property (p_quiet) else $error("write while busy");
  property p_hold; !i_fl_ready_busy_n && !o_erase_active |-> !o_done; endproperty
  a_hold: assert property (p_hold) else $error("done while busy");
  property p_take; s_take |=> o_busy ##[0:2] !o_fl_ce_n; endproperty
  a_take: assert property (p_take) else $error("request not started");
  property p_done; o_done |=> !o_done; endproperty
  a_done: assert property (p_done) else $error("done too long");
endmodule
bind fac_host fac_host_chk chk_u (.i_mclk, .i_rst_n, .i_ce, .i_req, .i_fl_ready_busy_n,
  .o_busy, .o_done, .o_erase_active, .o_fl_ce_n, .o_fl_oe_n, .o_fl_we_n, .o_fl_addr,
  .o_fl_dq, .o_fl_dq_oe);

// file: verification/flash_embedded_algorithm_ctrl_test.sv
// Bench for the flash host against the device model
module flash_embedded_algorithm_ctrl_test
  import fac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MANUF = 16'h005A; // Arbitrary value
  localparam logic [15:0] DEVICE = 16'h1234; // Arbitrary value
  logic i_mclk = 0, i_rst_n = 0, i_req = 0, i_byte_mode = 0, i_addr_lsb = 0;
  fac_op_t i_op = FAC_OP_READ;
  logic [17:0] i_addr = '0, o_fl_addr;
  logic [15:0] i_wdata = '0, o_rdata, i_fl_dq;
  logic [3:0] i_sector = '0;
  logic [1:0] i_id_sel = '0;
  logic [14:0] o_fl_dq;
  logic o_busy, o_done, o_erase_active, o_fl_ce_n, o_fl_oe_n, o_fl_we_n, o_fl_byte_n;
  logic o_fl_alsb, o_fl_alsb_oe, i_fl_ready_busy_n;
  int mismatches = 0, tests_run = 0;
  always #4 i_mclk = ~i_mclk;
  fac_host dut_u (.i_mclk, .i_rst_n, .i_ce(1'b1), .i_req, .i_op, .i_byte_mode, .i_addr,
    .i_addr_lsb, .i_wdata, .i_sector, .i_id_sel, .o_busy, .o_done, .o_erase_active, .o_rdata,
    .o_fl_ce_n, .o_fl_oe_n, .o_fl_we_n, .o_fl_byte_n, .o_fl_addr, .o_fl_alsb,
    .o_fl_alsb_oe, .o_fl_dq, .o_fl_dq_oe(), .i_fl_dq, .i_fl_ready_busy_n);
  fac_flash_model #(.MANUF_CODE(MANUF), .DEVICE_CODE(DEVICE)) dev_u (.i_clk(i_mclk),
    .i_ce_n(o_fl_ce_n), .i_oe_n(o_fl_oe_n), .i_we_n(o_fl_we_n), .i_byte_n(o_fl_byte_n),
    .i_addr(o_fl_addr), .i_alsb(o_fl_alsb), .i_dq(o_fl_dq), .o_dq(i_fl_dq),
    .o_ready_busy_n(i_fl_ready_busy_n));
  task automatic test_done;
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Issue one operation and wait for its completion pulse
  task automatic run(input fac_op_t o);
    int n;
    @(negedge i_mclk);
    i_op = o;
    i_req = 1'b1;
    @(negedge i_mclk);
    i_req = 1'b0;
    for (n = 0; n < 4000 && o_done !== 1'b1; n++) @(negedge i_mclk);
    if (n == 4000) begin
      chk("done timeout", 16'h1, 16'h0);
      test_done();
    end
  endtask
  task automatic t_byte;
    i_byte_mode = 1'b1;
    i_addr = 18'h00100;
    i_addr_lsb = 1'b1;
    i_wdata = 16'h00C3;
    run(FAC_OP_PROG);
    run(FAC_OP_READ);
    chk("byte readback", 16'h00C3, o_rdata);
    chk("address lsb drive", 16'h0001, {15'h0, o_fl_alsb_oe});
    i_addr_lsb = 1'b0;
    run(FAC_OP_READ);
    chk("byte neighbour", 16'h00FF, o_rdata);
    i_byte_mode = 1'b0;
  endtask
  task automatic t_word(input logic [15:0] v);
    i_addr = 18'h08004;
    i_wdata = v;
    run(FAC_OP_PROG);
    chk("ready after program", 16'h1, {15'h0, i_fl_ready_busy_n});
    run(FAC_OP_READ);
    chk("word readback", v, o_rdata);
    chk("address lsb released", 16'h0000, {15'h0, o_fl_alsb_oe});
  endtask
  task automatic t_id;
    i_id_sel = ID_MANUF;
    run(FAC_OP_ID);
    chk("manufacturer id", MANUF, o_rdata);
    i_id_sel = ID_DEVICE;
    run(FAC_OP_ID);
    chk("device id", DEVICE, o_rdata);
    i_id_sel = ID_PROTECT;
    i_sector = 4'h3;
    run(FAC_OP_ID);
    chk("protected sector", 16'h0001, o_rdata);
    i_sector = 4'h5;
    run(FAC_OP_ID);
    chk("open sector", 16'h0000, o_rdata);
    run(FAC_OP_RESET);
    run(FAC_OP_READ);
    chk("read after reset", 16'h3C5A, o_rdata);
  endtask
  task automatic t_sect;
    int n;
    i_sector = 4'h4;
    run(FAC_OP_SECT);
    chk("erase window", 16'h1, {15'h0, o_erase_active});
    run(FAC_OP_SUSP);
    run(FAC_OP_READ);
    chk("suspended read", 16'h3C5A, o_rdata);
    run(FAC_OP_RESUME);
    for (n = 0; n < 2000 && o_erase_active === 1'b1; n++) @(negedge i_mclk);
    chk("erase ended", 16'h0, {15'h0, o_erase_active});
    if (n == 2000) test_done();
    run(FAC_OP_READ);
    chk("sector erased", 16'hFFFF, o_rdata);
  endtask
  initial begin
    repeat (5) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst_n = 1'b1;
    chk("idle pins", 16'h000F, {12'h0, o_fl_ce_n, o_fl_oe_n, o_fl_we_n, o_fl_byte_n});
    t_byte();
    t_word(16'h3C5A);
    t_id();
    t_sect();
    t_word(16'h9234);
    run(FAC_OP_CHIP);
    run(FAC_OP_READ);
    chk("chip erased", 16'hFFFF, o_rdata);
    test_done();
  end
endmodule
